// >>> logic/cpbus_pkg.sv
// Shared constants and types for the coprocessor byte port and its bus master
package cpbus_pkg;
  // ==========================================================================
  // Decode terms
  localparam logic [2:0]  FC_CPU_SPACE   = 3'h7;
  localparam logic [3:0]  CP_COMM_SPACE  = 4'h2;
  localparam logic [2:0]  COPROCESSOR_IDENTIFIER_DEFAULT  = 3'h1;
  // ==========================================================================
  // Register offsets (A4-A0) and sizes
  localparam logic [4:0]  OFS_OPERAND    = 5'h10;
  localparam logic [4:0]  OFS_RESTORE    = 5'h0C;
  localparam int          EXT_BYTES      = 12;
  localparam int          NUM_FPREG      = 8;
  localparam logic [79:0] QNAN_VALUE     = 80'h7FFF_FFFF_FFFF_FFFF_FFFF;
  localparam logic [7:0]  NULL_FRAME     = 8'h00;
  // Acknowledge encodings, active low {ack1,ack0}
  localparam logic [1:0]  ACK_BYTE       = 2'h2;
  localparam logic [1:0]  ACK_WORD       = 2'h1;
  localparam logic [1:0]  ACK_LONG       = 2'h0;
  localparam logic [1:0]  ACK_NONE       = 2'h3;
  // Lane lookup indexed by {A4,A1,A0}; lane 3 = D31-D24
  localparam logic [15:0] LANE_MAP       = 16'h1B1B;
  localparam int          RST_POWERUP_CYC = 4;
  localparam int          RST_LATER_CYC   = 2;
  // ==========================================================================
  typedef enum logic [1:0] {PORT8, PORT16, PORT32} port_size_t;
  function automatic logic [1:0] lane_of(input logic [2:0] sel);
    lane_of = LANE_MAP[{sel, 1'b0} +: 2];
  endfunction
endpackage

// >>> logic/cpbus_if.sv
// Interface joining the coprocessor port and the main processor end
`timescale 1ns/1ps
interface cpbus_if;
  logic        as_n;
  logic        ds_n;
  logic        cs_n;
  logic        rw;
  logic        size_n;
  logic [4:0]  addr;
  logic [31:0] data_m;
  logic [31:0] data_d;
  logic [31:0] data_d_oe_n;
  logic [1:0]  ack_n;
  logic        reset_n;
  wire  [31:0] data = (~data_d_oe_n & data_d) | (data_d_oe_n & data_m);
  modport device (input as_n, ds_n, cs_n, rw, size_n, addr, data_m, reset_n,
                  output data_d, data_d_oe_n, ack_n);
  modport host (output as_n, ds_n, cs_n, rw, size_n, addr, data_m, reset_n,
                input data_d, ack_n, data_d_oe_n);
endinterface

// >>> logic/lane_steer.sv
// Byte lane steering for the eight-bit port
`timescale 1ns/1ps
module lane_steer
  import cpbus_pkg::*;
(
  input  wire logic [2:0]  SEL,
  input  wire logic [7:0]  BYTE_OUT,
  input  wire logic [31:0] BUS_IN,
  output logic      [31:0] BUS_OUT,
  output logic      [31:0] LANE_MASK,
  output logic      [7:0]  BYTE_IN
);
  logic [1:0] lane;
  // Table lookup of lane, MSB on bit 31/23/15/7
  always_comb
  begin
    lane      = lane_of(SEL);
    BUS_OUT   = 32'h0000_0000;
    LANE_MASK = 32'h0000_0000;
    BUS_OUT[lane*8 +: 8]   = BYTE_OUT;
    LANE_MASK[lane*8 +: 8] = 8'hFF;
    BYTE_IN   = BUS_IN[lane*8 +: 8];
  end
endmodule

// >>> logic/cp_port.sv
// Coprocessor end: eight-bit port, reset handling, access detection
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module cp_port
  import cpbus_pkg::*;
(
  input  wire logic        CLOCK,
  cpbus_if.device          BUS,
  input  wire logic [7:0]  OPLEN,
  input  wire logic        OPLOAD,
  input  wire logic [95:0] OPDATA,
  output logic      [1:0]  PORT_SIZE,
  output logic             BUSY,
  output logic      [95:0] OPRX,
  output logic             OPRX_DONE
);
  // ==========================================================================
  // Pin synchronisers, two flops on every bus input
  logic [1:0]  as_s;
  logic [1:0]  ds_s;
  logic [1:0]  cs_s;
  logic [1:0]  rw_s;
  logic [1:0]  sz_s;
  logic [1:0]  rst_s;
  logic [4:0]  a_s1;
  logic [4:0]  a_s2;
  logic [31:0] d_s1;
  logic [31:0] d_s2;
  // Strobes, select, direction, size and reset
  always_ff @(posedge CLOCK)
  begin
    as_s  <= {as_s[0], BUS.as_n};
    ds_s  <= {ds_s[0], BUS.ds_n};
    cs_s  <= {cs_s[0], BUS.cs_n};
    rw_s  <= {rw_s[0], BUS.rw};
    sz_s  <= {sz_s[0], BUS.size_n};
    rst_s <= {rst_s[0], BUS.reset_n};
  end
  // Address and write data, settled before the strobes arrive
  always_ff @(posedge CLOCK)
  begin
    a_s1 <= BUS.addr;
    a_s2 <= a_s1;
    d_s1 <= BUS.data_m;
    d_s2 <= d_s1;
  end
  // Active-high views of the synchronised strobes, select and direction; reset stays active low
  wire rst_n = rst_s[1];
  wire as = ~as_s[1];
  wire ds = ~ds_s[1];
  wire cs = ~cs_s[1];
  wire rd = rw_s[1];
  // ==========================================================================
  // Port size decode
  port_size_t psize;
  always_comb
  begin
    if (!sz_s[1])
      psize = PORT8;
    else if (a_s2[0])
      psize = PORT32;
    else
      psize = PORT16;
  end
  assign PORT_SIZE = psize;
  // ==========================================================================
  // Access detection
  typedef enum logic [1:0] {IDLE, ACTIVE, WAITEND} acc_t;
  acc_t st_ff;
  wire start = as & cs & (ds | ~rd);
  wire stop  = ~as | ~ds;
  // Access state: closed, strobes seen, waiting for a strobe to drop
  always_ff @(posedge CLOCK)
  begin
    if (!rst_n)
      st_ff <= IDLE;
    else
      case (st_ff)
        IDLE:
        begin
          if (start)
            st_ff <= ACTIVE;
        end
        ACTIVE:
        begin
          if (stop)
            st_ff <= IDLE;
          else if (ds)
            st_ff <= WAITEND;
        end
        WAITEND:
        begin
          if (stop)
            st_ff <= IDLE;
        end
        default:
          st_ff <= IDLE;
      endcase
  end
  // One byte taken per access; drive held while strobes stand
  wire take = (st_ff == ACTIVE) & ds & as; // one strobe per access
  wire acc_on = (st_ff != IDLE) & as & cs & ~stop;
  // ==========================================================================
  // Lane steering
  logic [31:0] bus_out;
  logic [31:0] lane_mask;
  logic [7:0]  byte_in;
  logic [7:0]  byte_out;
  lane_steer u_steer (
    .SEL       ({a_s2[4], a_s2[1], a_s2[0]}),
    .BYTE_OUT  (byte_out),
    .BUS_IN    (d_s2),
    .BUS_OUT   (bus_out),
    .LANE_MASK (lane_mask),
    .BYTE_IN   (byte_in)
  );
  // ==========================================================================
  // Operand sequencer, most significant byte first
  logic [95:0] opsh_ff;
  logic [7:0]  cnt_ff;
  logic [95:0] fpreg_ff [NUM_FPREG];
  logic [31:0] fp_control_register_ff;
  logic [31:0] fp_status_register_ff;
  logic        drv_ff;
  logic [31:0] dout_ff;
  logic [31:0] oe_n_ff;
  // Register select decode; null frame write re-initialises
  wire is_op = (a_s2 == OFS_OPERAND);
  wire is_rst = take & ~rd & (a_s2 == OFS_RESTORE) & (byte_in == NULL_FRAME);
  assign byte_out = opsh_ff[95:88];
  // Load, shift or abandon the operand transfer
  always_ff @(posedge CLOCK)
  begin
    // Null restore drops a transfer in progress, like reset
    if (!rst_n || is_rst)
    begin
      opsh_ff <= 96'h0;
      cnt_ff  <= 8'h00;
    end
    else if (OPLOAD)
    begin
      opsh_ff <= OPDATA;
      cnt_ff  <= OPLEN;
    end
    else if (take & is_op & psize == PORT8 & cnt_ff != 8'h00)
    begin
      opsh_ff <= {opsh_ff[87:0], byte_in};
      cnt_ff  <= cnt_ff - 8'h01;
    end
  end
  // Transfer open while bytes remain
  assign BUSY = (cnt_ff != 8'h00);
  // Pulse when the last written byte lands
  always_ff @(posedge CLOCK)
  begin
    if (!rst_n)
      OPRX_DONE <= 1'b0;
    else
      OPRX_DONE <= take & is_op & ~rd & (cnt_ff == 8'h01);
  end
  assign OPRX = opsh_ff;
  // Reset and null restore initialise registers
  genvar g;
  generate
    for (g = 0; g < NUM_FPREG; g++)
    begin : g_reg
      always_ff @(posedge CLOCK)
      begin
        if (!rst_n || is_rst)
          fpreg_ff[g] <= {16'h0000, QNAN_VALUE};
      end
    end
  endgenerate
  always_ff @(posedge CLOCK)
  begin
    if (!rst_n || is_rst)
    begin
      fp_control_register_ff <= 32'h0000_0000;
      fp_status_register_ff <= 32'h0000_0000;
    end
  end
  // ==========================================================================
  // Data drive and acknowledge
  // Registered lane drive, released once the access closes
  always_ff @(posedge CLOCK)
  begin
    if (!rst_n)
    begin
      drv_ff  <= 1'b0;
      dout_ff <= 32'h0000_0000;
      oe_n_ff <= 32'hFFFF_FFFF;
    end
    else
    begin
      drv_ff  <= acc_on;
      dout_ff <= bus_out;
      oe_n_ff <= (acc_on & rd) ? ~lane_mask : 32'hFFFF_FFFF;
    end
  end
  assign BUS.data_d      = dout_ff;
  assign BUS.data_d_oe_n = oe_n_ff;
  // Acknowledge code follows the port size while an access is open
  always_comb
  begin
    if (!drv_ff)
      BUS.ack_n = ACK_NONE;
    else
      case (psize)
        PORT8:   BUS.ack_n = ACK_BYTE;
        PORT32:  BUS.ack_n = ACK_LONG;
        PORT16:  BUS.ack_n = ACK_WORD;
        default: BUS.ack_n = ACK_NONE;
      endcase
  end
endmodule

// >>> logic/host_master.sv
// Main processor end: byte cycles toward the coprocessor
`timescale 1ns/1ps
module host_master
  import cpbus_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  cpbus_if.host            BUS,
  input  wire logic        REQ,
  input  wire logic        WR,
  input  wire logic [4:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  output logic      [7:0]  RDATA,
  output logic             DONE,
  output logic             READY
);
  typedef enum logic [2:0] {H_RST, H_IDLE, H_ASSERT, H_WAIT, H_END} hst_t;
  hst_t st_ff;
  logic [2:0] rcnt_ff;
  logic       rw_ff, strobe_ff, cs_ff;
  logic [4:0] a_ff;
  logic [7:0] w_ff;
  // Reset pulse held four clocks at start
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
      rcnt_ff <= 3'h0;
    else if (rcnt_ff != 3'(RST_POWERUP_CYC))
      rcnt_ff <= rcnt_ff + 3'h1;
  end
  assign BUS.reset_n = (rcnt_ff == 3'(RST_POWERUP_CYC));
  // Cycle sequencer
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      st_ff <= H_RST;
      rw_ff     <= 1'b1;
      strobe_ff <= 1'b0;
      cs_ff     <= 1'b0;
      a_ff      <= 5'h00;
      w_ff      <= 8'h00;
      RDATA     <= 8'h00;
      DONE      <= 1'b0;
    end
    else
    begin
      DONE <= 1'b0;
      case (st_ff)
        H_RST:
          if (BUS.reset_n)
            st_ff <= H_IDLE;
        H_IDLE:
          if (REQ)
          begin
            a_ff  <= ADDR;
            w_ff  <= WDATA;
            rw_ff <= ~WR;
            cs_ff <= 1'b1;
            st_ff <= H_ASSERT;
          end
        H_ASSERT:
        begin
          strobe_ff <= 1'b1;
          st_ff     <= H_WAIT;
        end
        H_WAIT:
          if (BUS.ack_n != ACK_NONE)
          begin
            RDATA     <= BUS.data_d[lane_of({a_ff[4], a_ff[1], a_ff[0]})*8 +: 8];
            strobe_ff <= 1'b0;
            st_ff     <= H_END;
          end
        H_END:
        begin
          cs_ff <= 1'b0;
          DONE  <= 1'b1;
          st_ff <= H_IDLE;
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end
  assign READY = (st_ff == H_IDLE);
  assign BUS.as_n   = ~strobe_ff;
  assign BUS.ds_n   = ~strobe_ff;
  assign BUS.cs_n   = ~cs_ff;
  assign BUS.rw     = rw_ff;
  assign BUS.size_n = 1'b0;
  assign BUS.addr   = a_ff;
  assign BUS.data_m = {4{w_ff}};
endmodule

// >>> verification/cp_port_asserts.sv
// Bus checks between the coprocessor end and the host end
`timescale 1ns/1ps
module cp_port_asserts
  import cpbus_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        as_n,
  input wire logic        ds_n,
  input wire logic        cs_n,
  input wire logic        rw,
  input wire logic        size_n,
  input wire logic [4:0]  addr,
  input wire logic [31:0] data_d_oe_n,
  input wire logic [1:0]  ack_n,
  input wire logic        reset_n
);
  // Expected lane from the address
  logic [1:0]  lane;
  logic [31:0] drv;
  assign lane = LANE_MAP[{addr[4], addr[1], addr[0], 1'b0} +: 2];
  assign drv  = ~data_d_oe_n;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Acknowledge
  property p_ack_byte;
    (ack_n != ACK_NONE && !size_n) |-> ack_n == ACK_BYTE;
  endproperty
  a_ack_byte: assert property (p_ack_byte) else $error("ack not byte size");
  property p_ack_gated;
    ($past(ack_n) == ACK_NONE && ack_n != ACK_NONE) |-> $past(!as_n && !cs_n)
      && $past(!as_n && !cs_n, 3);
  endproperty
  a_ack_gated: assert property (p_ack_gated) else $error("ack without strobe");
  property p_latency;
    ($fell(as_n) && !cs_n) |-> ##[1:8] ack_n != ACK_NONE;
  endproperty
  a_latency: assert property (p_latency) else $error("access not seen");
  property p_ack_hold;
    (ack_n != ACK_NONE && !as_n && !ds_n) |=> ack_n != ACK_NONE;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  property p_release;
    $rose(as_n) |-> ##[1:6] ack_n == ACK_NONE;
  endproperty
  a_release: assert property (p_release) else $error("ack not released");
  // ==========================================================================
  // Byte lanes and reset
  property p_lane;
    (!as_n && !(&data_d_oe_n)) |-> drv == (32'hFF << (8 * lane));
  endproperty
  a_lane: assert property (p_lane) else $error("wrong byte lane");
  property p_no_drive_write;
    (!as_n && !ds_n && !rw) |-> &data_d_oe_n;
  endproperty
  a_no_drive_write: assert property (p_no_drive_write) else $error("drive in write");
  property p_reset_idle;
    disable iff (1'b0) $rose(reset_n) |-> ack_n == ACK_NONE && &data_d_oe_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle on reset");
  c_read_drive: cover property (!as_n && !(&data_d_oe_n));
  c_write_ack: cover property (!rw && ack_n == ACK_BYTE);
  c_reset: cover property ($rose(reset_n));
endmodule

// >>> verification/tb_coproc_byte_port_reset_select.sv
// Self-checking bench with both ends joined by the bus interface
`timescale 1ns/1ps
module tb_coproc_byte_port_reset_select;
  import cpbus_pkg::*;
  logic        clock  = 1'b0;
  logic        resetn = 1'b0;
  logic        req    = 1'b0;
  logic        wr     = 1'b0;
  logic [4:0]  addr   = 5'h00;
  logic [7:0]  wdata  = 8'h00;
  logic [7:0]  oplen  = 8'h00;
  logic        opload = 1'b0;
  logic [95:0] opdata = 96'h0;
  logic [95:0] wv;
  logic [95:0] oprx;
  logic [7:0]  rdata;
  logic [1:0]  port_size;
  logic        busy;
  logic        done;
  logic        ready;
  logic        oprx_done;
  int          n_done      = 0;
  int          done_base   = 0;
  int          miscompares = 0;
  int          n_compared  = 0;
  integer      seed        = 15930;
  int          lens[3]     = '{1, 4, 12};
  always #10 clock = ~clock;
  // ==========================================================================
  // Both ends, the bus and the checker
  cpbus_if u_cpbus_if ();
  cp_port u_cp_port (.CLOCK(clock), .BUS(u_cpbus_if.device), .OPLEN(oplen), .OPLOAD(opload),
    .OPDATA(opdata), .PORT_SIZE(port_size), .BUSY(busy), .OPRX(oprx), .OPRX_DONE(oprx_done));
  host_master u_host_master (.CLOCK(clock), .RESETN(resetn), .BUS(u_cpbus_if.host), .REQ(req),
    .WR(wr), .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .DONE(done), .READY(ready));
  // Count last-byte pulses of the operand sequencer
  always @(posedge clock)
    if (oprx_done === 1'b1)
      n_done++;
  cp_port_asserts u_cp_port_asserts (.CLOCK(clock), .as_n(u_cpbus_if.as_n),
    .ds_n(u_cpbus_if.ds_n), .cs_n(u_cpbus_if.cs_n), .rw(u_cpbus_if.rw),
    .size_n(u_cpbus_if.size_n), .addr(u_cpbus_if.addr), .data_d_oe_n(u_cpbus_if.data_d_oe_n),
    .ack_n(u_cpbus_if.ack_n), .reset_n(u_cpbus_if.reset_n));
  // ==========================================================================
  // Helpers
  function automatic logic [7:0] byte_at(input logic [95:0] v, input int i);
    return v[95 - 8 * i -: 8];
  endfunction
  task automatic cmp(input logic [95:0] got, input logic [95:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One host byte cycle, bounded wait for completion
  task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cmp(96'(ready), 96'h1);
    req   <= 1'b1;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    req   <= 1'b0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (done !== 1'b1 && n < 60);
    if (n >= 60)
    begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic load(input logic [7:0] len);
    @(posedge clock);
    oplen  <= len;
    opdata <= {$random(seed), $random(seed), $random(seed)};
    opload <= 1'b1;
    @(posedge clock);
    opload <= 1'b0;
  endtask
  task automatic test_done();
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    repeat (12) @(posedge clock);
    cmp(96'(port_size), 96'(PORT8));
    load(8'd12);
    access(1'b0, OFS_OPERAND, 8'h00);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (12) @(posedge clock);
    cmp(96'(busy), 96'h0);
    cmp(96'(u_cpbus_if.ack_n), 96'(ACK_NONE));
    foreach (lens[k])
    begin
      load(8'(lens[k]));
      for (int i = 0; i < lens[k]; i++)
      begin
        access(1'b0, OFS_OPERAND, 8'h00);
        cmp(96'(rdata), 96'(byte_at(opdata, i)));
      end
      cmp(96'(busy), 96'h0);
    end
    wv = {$random(seed), $random(seed), $random(seed)};
    load(8'd12);
    done_base = n_done;
    for (int i = 0; i < 12; i++)
      access(1'b1, OFS_OPERAND, byte_at(wv, i));
    cmp(oprx, wv);
    cmp(96'(n_done - done_base), 96'h1);
    load(8'd12);
    access(1'b1, OFS_RESTORE, NULL_FRAME);
    cmp(96'(busy), 96'h0);
    for (int i = 0; i < 24; i++)
      access(1'($random(seed)), 5'($random(seed)), 8'($random(seed)));
    test_done();
  end
  // Watchdog against a hung handshake
  initial
  begin
    #400000;
    miscompares++;
    test_done();
  end
endmodule
